// File: common/eeac_pkg.sv
// eeac_pkg: shared constants and types for the nonvolatile byte access block.
// assumes a 6-bit I/O register space with byte-wide data, one register per address.
`default_nettype none

package eeac_pkg;

  // I/O register addresses
  localparam logic [5:0] EEAC_OFS_STORE_ZERO = 6'h1e;
  localparam logic [5:0] EEAC_OFS_CONTROL    = 6'h1f;
  localparam logic [5:0] EEAC_OFS_DATA       = 6'h20;
  localparam logic [5:0] EEAC_OFS_ADDR_LO    = 6'h21;
  localparam logic [5:0] EEAC_OFS_ADDR_HI    = 6'h22;
  localparam logic [5:0] EEAC_OFS_STORE_ONE  = 6'h2a;

  // nv_control field positions
  localparam int EEAC_BIT_READ_STROBE  = 0;
  localparam int EEAC_BIT_WRITE_STROBE = 1;
  localparam int EEAC_BIT_WRITE_ARM    = 2;
  localparam int EEAC_BIT_READY_IRQ_EN = 3;
  localparam int EEAC_BIT_MODE_LO      = 4;
  localparam int EEAC_BIT_MODE_HI      = 5;

  // reset values and the erased cell value
  localparam logic [7:0] EEAC_RST_STORE = 8'h00;
  localparam logic [7:0] EEAC_RST_DATA  = 8'h00;
  localparam logic [9:0] EEAC_RST_ADDR  = 10'h000;
  localparam logic [7:0] EEAC_ERASED    = 8'hff;

  // cycle counts on clk
  localparam int EEAC_ARM_WINDOW = 4;
  localparam int EEAC_WRITE_STALL = 2;
  localparam int EEAC_READ_STALL  = 4;

  // write timing, in calibrated oscillator ticks and in microseconds
  localparam int EEAC_ATOMIC_TICKS = 26368;
  localparam int EEAC_ATOMIC_US    = 3400;
  localparam int EEAC_SPLIT_US     = 1800;
  localparam int EEAC_SPLIT_TICKS  = EEAC_ATOMIC_TICKS * EEAC_SPLIT_US / EEAC_ATOMIC_US;

  typedef enum logic [1:0] {
    EEAC_MODE_ATOMIC   = 2'b00,
    EEAC_MODE_ERASE    = 2'b01,
    EEAC_MODE_WRITE    = 2'b10,
    EEAC_MODE_RESERVED = 2'b11
  } eeac_mode_t;

  typedef enum logic {
    EEAC_WS_IDLE = 1'b0,
    EEAC_WS_BUSY = 1'b1
  } eeac_wstate_t;

endpackage : eeac_pkg

`default_nettype wire

// File: design/eeac_cell_array.sv
// eeac_cell_array: the byte cells of the nonvolatile store.
// assumes the controller pulses prog_en once per finished program cycle.
`timescale 1ns/1ns
`default_nettype none

module eeac_cell_array
  import eeac_pkg::*;
#(
  parameter int ADDR_W = 10,
  parameter int DEPTH  = 1024
) (
  input  wire logic              clk,       // system clock
  input  wire logic              ce,        // clock enable
  input  wire logic [ADDR_W-1:0] rd_addr,   // read address
  output logic      [7:0]        rd_data,   // cell contents at rd_addr
  input  wire logic              prog_en,   // commit one program cycle
  input  wire eeac_mode_t        prog_mode, // operation of that cycle
  input  wire logic [ADDR_W-1:0] prog_addr, // target cell
  input  wire logic [7:0]        prog_data  // data to program
);

  // no reset: contents are meant to survive it
  logic [7:0] cells [DEPTH];

  assign rd_data = cells[rd_addr];

  always_ff @(posedge clk) begin
    if (ce && prog_en) begin
      unique case (prog_mode)
        EEAC_MODE_ATOMIC: cells[prog_addr] <= prog_data;
        EEAC_MODE_ERASE:  cells[prog_addr] <= EEAC_ERASED;
        // write only can clear bits, never set them
        EEAC_MODE_WRITE:  cells[prog_addr] <= cells[prog_addr] & prog_data;
        default:          cells[prog_addr] <= cells[prog_addr];
      endcase
    end
  end

endmodule : eeac_cell_array

`default_nettype wire

// File: design/eeac_control.sv
// eeac_control: register file, armed write sequence, write timing and CPU stall
// for byte access to the on-chip nonvolatile store.
// assumes an I/O register port synchronous to clk and an oscillator tick pulse
// synchronous to clk, one cycle per calibrated oscillator period.
`timescale 1ns/1ns
`default_nettype none

module eeac_control
  import eeac_pkg::*;
#(
  parameter int ADDR_W       = 10,
  parameter int DEPTH        = 1024,
  parameter int ATOMIC_TICKS = EEAC_ATOMIC_TICKS,
  parameter int SPLIT_TICKS  = EEAC_SPLIT_TICKS,
  parameter int TICK_W       = 15
) (
  input  wire logic       clk,               // system clock, 100 MHz
  input  wire logic       nrst,              // async reset, active low
  input  wire logic       ce,                // clock enable, freezes all state
  input  wire logic       sys_rst_n,         // sync system reset, active low
  input  wire logic [5:0] io_addr,           // I/O register address
  input  wire logic [7:0] io_wdata,          // I/O write data
  input  wire logic       io_we,             // I/O write strobe
  input  wire logic       io_re,             // I/O read strobe
  output logic      [7:0] io_rdata,          // I/O read data, one cycle after io_re
  input  wire logic       rc_tick,           // calibrated oscillator tick
  input  wire logic       self_program_busy, // flash self-programming active
  input  wire logic       global_irq_en,     // CPU global interrupt enable
  output logic            cpu_stall,         // halt CPU
  output logic            ready_irq          // ready interrupt request level
);

  eeac_wstate_t            wstate_reg;
  logic                    arm_reg;
  logic [1:0]              arm_cnt_reg;
  logic                    rie_reg;
  eeac_mode_t              mode_reg;
  eeac_mode_t              prog_mode_reg;
  logic [7:0]              prog_data_reg;
  logic [TICK_W-1:0]       tick_cnt_reg;
  logic [ADDR_W-1:0]       addr_reg;
  logic [7:0]              data_reg;
  logic [7:0]              store0_reg;
  logic [7:0]              store1_reg;
  logic [1:0]              stall_cnt_reg;
  logic                    stall_reg;
  logic                    irq_reg;
  logic [7:0]              rdata_reg;
  logic [7:0]              cell_rd;
  logic                    idle;
  logic                    io_live;
  logic                    ctl_wr;
  logic                    strobe_go;
  logic                    read_go;
  logic                    tick_last;
  logic                    prog_en;
  logic [7:0]              ctl_view;
  logic [7:0]              addr_hi_view;

  assign idle    = (wstate_reg == EEAC_WS_IDLE);
  assign io_live = io_we && sys_rst_n;
  assign ctl_wr  = io_live && (io_addr == EEAC_OFS_CONTROL);

  // a reserved mode is refused outright rather than timed as a no-op
  assign strobe_go = ctl_wr && io_wdata[EEAC_BIT_WRITE_STROBE]
                     && arm_reg
                     && idle
                     && !self_program_busy
                     && (mode_reg != EEAC_MODE_RESERVED);

  assign read_go = ctl_wr && io_wdata[EEAC_BIT_READ_STROBE] && idle;

  assign tick_last = (prog_mode_reg == EEAC_MODE_ATOMIC)
                     ? (tick_cnt_reg == TICK_W'(ATOMIC_TICKS - 1))
                     : (tick_cnt_reg == TICK_W'(SPLIT_TICKS - 1));

  assign prog_en = !idle && rc_tick && tick_last;

  // strobe bit is the busy state itself; read strobe always reads zero
  assign ctl_view = {2'b00, mode_reg, rie_reg, arm_reg, !idle, 1'b0};
  assign addr_hi_view = {{(16 - ADDR_W){1'b0}}, addr_reg[ADDR_W-1:8]};

  // arm window
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arm_reg     <= 1'b0;
      arm_cnt_reg <= 2'h0;
    end else if (ce) begin
      if (!sys_rst_n || strobe_go) begin
        arm_reg     <= 1'b0;
        arm_cnt_reg <= 2'h0;
      end else if (ctl_wr && io_wdata[EEAC_BIT_WRITE_ARM]) begin
        arm_reg     <= 1'b1;
        arm_cnt_reg <= 2'(EEAC_ARM_WINDOW - 1);
      end else if (arm_reg) begin
        if (arm_cnt_reg == 2'h0) begin
          arm_reg <= 1'b0;
        end else begin
          arm_cnt_reg <= arm_cnt_reg - 2'h1;
        end
      end
    end
  end

  // write sequencer, runs on through a system reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wstate_reg    <= EEAC_WS_IDLE;
      tick_cnt_reg  <= '0;
      prog_mode_reg <= EEAC_MODE_ATOMIC;
      prog_data_reg <= EEAC_RST_DATA;
    end else if (ce) begin
      unique case (wstate_reg)
        EEAC_WS_IDLE: begin
          if (strobe_go) begin
            wstate_reg    <= EEAC_WS_BUSY;
            tick_cnt_reg  <= '0;
            prog_mode_reg <= mode_reg;
            prog_data_reg <= data_reg;
          end
        end
        EEAC_WS_BUSY: begin
          if (rc_tick) begin
            if (tick_last) begin
              wstate_reg <= EEAC_WS_IDLE;
            end else begin
              tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
            end
          end
        end
      endcase
    end
  end

  // mode and ready enable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= EEAC_MODE_ATOMIC;
      rie_reg  <= 1'b0;
    end else if (ce) begin
      if (!sys_rst_n) begin
        rie_reg <= 1'b0;
        if (idle) begin
          mode_reg <= EEAC_MODE_ATOMIC;
        end
      end else if (ctl_wr) begin
        rie_reg <= io_wdata[EEAC_BIT_READY_IRQ_EN];
        if (idle) begin
          mode_reg <= eeac_mode_t'(io_wdata[EEAC_BIT_MODE_HI:EEAC_BIT_MODE_LO]);
        end
      end
    end
  end

  // address, frozen while a write runs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_reg <= EEAC_RST_ADDR;
    end else if (ce) begin
      if (!sys_rst_n) begin
        if (idle) begin
          addr_reg <= EEAC_RST_ADDR;
        end
      end else if (io_live && idle) begin
        if (io_addr == EEAC_OFS_ADDR_LO) begin
          addr_reg[7:0] <= io_wdata;
        end else if (io_addr == EEAC_OFS_ADDR_HI) begin
          addr_reg[ADDR_W-1:8] <= io_wdata[ADDR_W-9:0];
        end
      end
    end
  end

  // data register: software load or read result
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_reg <= EEAC_RST_DATA;
    end else if (ce) begin
      if (!sys_rst_n) begin
        data_reg <= EEAC_RST_DATA;
      end else if (read_go) begin
        data_reg <= cell_rd;
      end else if (io_live && io_addr == EEAC_OFS_DATA) begin
        data_reg <= io_wdata;
      end
    end
  end

  // general stores
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      store0_reg <= EEAC_RST_STORE;
      store1_reg <= EEAC_RST_STORE;
    end else if (ce) begin
      if (!sys_rst_n) begin
        store0_reg <= EEAC_RST_STORE;
        store1_reg <= EEAC_RST_STORE;
      end else if (io_live && io_addr == EEAC_OFS_STORE_ZERO) begin
        store0_reg <= io_wdata;
      end else if (io_live && io_addr == EEAC_OFS_STORE_ONE) begin
        store1_reg <= io_wdata;
      end
    end
  end

  // CPU stall; a read stalls longer, so it wins if both start together
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stall_reg     <= 1'b0;
      stall_cnt_reg <= 2'h0;
    end else if (ce) begin
      if (read_go) begin
        stall_reg     <= 1'b1;
        stall_cnt_reg <= 2'(EEAC_READ_STALL - 1);
      end else if (strobe_go) begin
        stall_reg     <= 1'b1;
        stall_cnt_reg <= 2'(EEAC_WRITE_STALL - 1);
      end else if (stall_reg) begin
        if (stall_cnt_reg == 2'h0) begin
          stall_reg <= 1'b0;
        end else begin
          stall_cnt_reg <= stall_cnt_reg - 2'h1;
        end
      end
    end
  end

  // ready interrupt is a level, held off during flash self-programming too
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_reg <= 1'b0;
    end else if (ce) begin
      irq_reg <= rie_reg && global_irq_en && idle && !self_program_busy;
    end
  end

  // read-back; unmapped addresses return zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else if (ce && io_re) begin
      unique case (io_addr)
        EEAC_OFS_STORE_ZERO: rdata_reg <= store0_reg;
        EEAC_OFS_CONTROL:    rdata_reg <= ctl_view;
        EEAC_OFS_DATA:       rdata_reg <= data_reg;
        EEAC_OFS_ADDR_LO:    rdata_reg <= addr_reg[7:0];
        EEAC_OFS_ADDR_HI:    rdata_reg <= addr_hi_view;
        EEAC_OFS_STORE_ONE:  rdata_reg <= store1_reg;
        default:             rdata_reg <= 8'h00;
      endcase
    end
  end

  assign io_rdata  = rdata_reg;
  assign cpu_stall = stall_reg;
  assign ready_irq = irq_reg;

  // commit lands on the same edge that clears the strobe bit
  eeac_cell_array #(
    .ADDR_W (ADDR_W),
    .DEPTH  (DEPTH)
  ) u_cells (
    .clk       (clk),
    .ce        (ce),
    .rd_addr   (addr_reg),
    .rd_data   (cell_rd),
    .prog_en   (prog_en),
    .prog_mode (prog_mode_reg),
    .prog_addr (addr_reg),
    .prog_data (prog_data_reg)
  );

endmodule : eeac_control

`default_nettype wire

// File: verif/eeac_control_props.sv
// eeac_control_props: port-level checks for the nonvolatile access controller.
// assumes ready irq enable is set whenever stall checks are meant to engage.
`timescale 1ns/1ns
`default_nettype none

module eeac_control_props
  import eeac_pkg::*;
(
  input wire logic       clk,               // system clock
  input wire logic       nrst,              // async reset, active low
  input wire logic       ce,                // clock enable
  input wire logic       sys_rst_n,         // sync system reset
  input wire logic [5:0] io_addr,           // register address
  input wire logic [7:0] io_wdata,          // write data
  input wire logic       io_we,             // write strobe
  input wire logic       io_re,             // read strobe
  input wire logic [7:0] io_rdata,          // read data
  input wire logic       rc_tick,           // oscillator tick
  input wire logic       self_program_busy, // flash busy
  input wire logic       global_irq_en,     // global irq enable
  input wire logic       cpu_stall,         // cpu halt
  input wire logic       ready_irq          // ready irq level
);
  logic       ctl_we;
  logic       wr_go;
  logic       rd_go;
  logic [2:0] arm_age;
  logic [1:0] arm_mode;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  assign ctl_we = ce && sys_rst_n && io_we && (io_addr == EEAC_OFS_CONTROL);
  // ready_irq high means idle a cycle ago, so busy cannot hide behind it
  assign wr_go = ctl_we && io_wdata[1] && !io_wdata[2] && !io_wdata[0] && (io_wdata[5:4] != 2'b11)
                 && (arm_mode != 2'b11) && (arm_age != 3'h0) && !self_program_busy && ready_irq && !cpu_stall;
  assign rd_go = ctl_we && io_wdata[0] && !io_wdata[1] && ready_irq && !cpu_stall;

  // age of the last arm write, 1..4 is the acceptance window
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arm_age  <= 3'h0;
      arm_mode <= 2'b00;
    end else if (ce && !sys_rst_n) begin
      arm_age <= 3'h0;
    end else if (ctl_we && io_wdata[2]) begin
      arm_age  <= 3'h1;
      arm_mode <= io_wdata[5:4];
    end else if (ce && arm_age != 3'h0) begin
      arm_age <= (arm_age == 3'h4) ? 3'h0 : arm_age + 3'h1;
    end
  end

  a_armed_write_stall: assert property (wr_go |=> cpu_stall [*2] ##1 !cpu_stall)
    else $error("armed strobe did not stall two cycles");
  a_write_hides_ready: assert property (wr_go |=> ##1 !ready_irq [*3])
    else $error("ready irq during write");
  a_unarmed_strobe: assert property (ctl_we && io_wdata[1:0] == 2'b10 && arm_age == 3'h0 && !cpu_stall
                                     |=> !cpu_stall)
    else $error("unarmed strobe took effect");
  a_flash_lockout: assert property (ctl_we && io_wdata[1:0] == 2'b10 && self_program_busy && !cpu_stall
                                    |=> !cpu_stall)
    else $error("write started during flash programming");
  a_read_stall_len: assert property (rd_go |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall not four cycles");
  a_ready_gate: assert property (ready_irq |-> $past(global_irq_en) && !$past(self_program_busy))
    else $error("ready irq without enable");
  a_rdata_stands: assert property (!(ce && io_re) |=> $stable(io_rdata))
    else $error("read data changed without read");
  a_addr_hi_zero: assert property (ce && io_re && io_addr == EEAC_OFS_ADDR_HI
                                   |=> io_rdata[7:2] == 6'h00)
    else $error("address high reserved bits nonzero");
  a_ctl_fixed_zero: assert property (ce && io_re && io_addr == EEAC_OFS_CONTROL
                                     |=> io_rdata[7:6] == 2'b00 && !io_rdata[0])
    else $error("control fixed bits nonzero");

  c_write: cover property (wr_go);
  c_read: cover property (rd_go);
  c_refused: cover property (ctl_we && io_wdata[1:0] == 2'b10 && arm_age == 3'h0);
endmodule : eeac_control_props

`default_nettype wire

// File: verif/eeac_control_tb.sv
// eeac_control_tb: self-checking bench for the nonvolatile access controller.
// assumes short tick counts; cells are read back only after being programmed.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t %s", $time, m); end end

module eeac_control_tb
  import eeac_pkg::*;
;
  localparam int AT = 8;
  localparam int ST = 4;
  localparam logic [5:0] CT = EEAC_OFS_CONTROL;
  logic       clk = 1'b0, nrst = 1'b0, sys_rst_n = 1'b1, io_we = 1'b0, io_re = 1'b0, rc_tick = 1'b0;
  logic       self_program_busy = 1'b0, global_irq_en = 1'b1, cpu_stall, ready_irq, tick_on = 1'b0;
  logic       ce = 1'b1;
  logic [5:0] io_addr = 6'h00;
  logic [7:0] io_wdata = 8'h00, io_rdata, tmp;
  logic [9:0] a;
  logic [31:0] seed = 32'd79;
  int         error_cnt = 0, checks = 0, tk = 0, opn = 0;
  logic [7:0] mem [int];
  logic [7:0] expq [$];

  eeac_control #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) eeac_control_i (
    .clk, .nrst, .ce, .sys_rst_n, .io_addr, .io_wdata, .io_we, .io_re, .io_rdata,
    .rc_tick, .self_program_busy, .global_irq_en, .cpu_stall, .ready_irq);

  always #5 clk = ~clk;

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  task automatic close_out();
    $display("counts: checks=%0d mismatches=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  // one call is one cycle, so back-to-back requests never double-assign
  task automatic op(logic we, logic re, logic [5:0] ad, logic [7:0] d);
    @(negedge clk);
    io_we = we;
    io_re = re;
    io_addr = ad;
    io_wdata = d;
    rc_tick = tick_on && (opn % 4 == 0);
    if (rc_tick) tk++;
    opn++;
  endtask : op

  task automatic wr(logic [5:0] ad, logic [7:0] d); op(1'b1, 1'b0, ad, d); endtask : wr
  task automatic rd(logic [5:0] ad, logic [7:0] e); op(1'b0, 1'b1, ad, 8'h00); expq.push_back(e); endtask : rd
  task automatic idle(int n); repeat (n) op(1'b0, 1'b0, 6'h00, 8'h00); endtask : idle
  task automatic tst(string s); $display("test done: %s", s); endtask : tst

  task automatic stall_chk(int n);
    for (int i = 0; i <= n; i++) begin
      idle(1);
      `CHK(cpu_stall, i < n, "stall length")
    end
  endtask : stall_chk

  task automatic wait_tk(int n);
    for (int i = 0; i < 300 && tk < n; i++) idle(1);
    if (tk < n) begin
      error_cnt++;
      close_out();
    end
  endtask : wait_tk

  task automatic wr_cell(logic [1:0] m, logic [9:0] ad, logic [7:0] d, int gap, bit ok, bit poke);
    int t0;
    logic [7:0] mc;
    mc = {2'b00, m, 4'b1000};
    wr(EEAC_OFS_ADDR_LO, ad[7:0]);
    wr(EEAC_OFS_ADDR_HI, {6'h00, ad[9:8]});
    wr(EEAC_OFS_DATA, d);
    if (gap == 0) wr(CT, mc | 8'h06);
    else begin
      wr(CT, mc | 8'h04);
      idle(gap - 1);
      wr(CT, mc | 8'h02);
    end
    stall_chk(ok ? 2 : 0);
    if (!ok) begin
      idle(5);
      rd(CT, mc);
    end else begin
      if (poke) begin
        wr(EEAC_OFS_ADDR_LO, ~ad[7:0]);
        wr(CT, 8'h19);
        stall_chk(0);
        rd(EEAC_OFS_DATA, d);
      end
      t0 = tk;
      tick_on = 1'b1;
      wait_tk(t0 + (m == 2'b00 ? AT : ST) - 1);
      rd(CT, mc | 8'h02);
      `CHK(ready_irq, 1'b0, "ready during write")
      wait_tk(t0 + (m == 2'b00 ? AT : ST));
      rd(CT, mc);
      tick_on = 1'b0;
      if (poke) rd(EEAC_OFS_ADDR_LO, ad[7:0]);
      mem[ad] = (m == 2'b00) ? d : (m == 2'b01) ? 8'hff : mem[ad] & d;
    end
  endtask : wr_cell

  task automatic rd_cell(logic [9:0] ad);
    wr(EEAC_OFS_ADDR_LO, ad[7:0]);
    wr(EEAC_OFS_ADDR_HI, {6'h00, ad[9:8]});
    wr(CT, 8'h09);
    stall_chk(4);
    rd(EEAC_OFS_DATA, mem[ad]);
  endtask : rd_cell

  always @(posedge clk) begin
    if (io_re === 1'b1) begin
      @(negedge clk);
      `CHK(io_rdata, expq.pop_front(), "read data")
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    mem.delete();
    rd(EEAC_OFS_STORE_ZERO, 8'h00);
    rd(EEAC_OFS_STORE_ONE, 8'h00);
    rd(CT, 8'h00);
    rd(EEAC_OFS_ADDR_HI, 8'h00);
    tst("reset");
    tmp = rnd();
    wr(EEAC_OFS_STORE_ZERO, tmp);
    rd(EEAC_OFS_STORE_ZERO, tmp);
    idle(1);
    // write offered while frozen must not land
    ce = 1'b0;
    wr(EEAC_OFS_STORE_ZERO, ~tmp);
    idle(1);
    ce = 1'b1;
    rd(EEAC_OFS_STORE_ZERO, tmp);
    tmp = rnd();
    wr(EEAC_OFS_STORE_ONE, tmp);
    rd(EEAC_OFS_STORE_ONE, tmp);
    wr(6'h10, 8'h5a);
    rd(6'h10, 8'h00);
    wr(EEAC_OFS_ADDR_HI, 8'hff);
    rd(EEAC_OFS_ADDR_HI, 8'h03);
    tst("registers");
    wr(CT, 8'h0c);
    rd(CT, 8'h0c);
    idle(3);
    rd(CT, 8'h08);
    tst("arm timeout");
    tmp = rnd();
    a = {tmp[1:0], rnd()};
    wr_cell(2'b00, a, rnd(), 1, 1'b1, 1'b0);
    wr_cell(2'b00, a ^ 10'h001, rnd(), 4, 1'b1, 1'b1);
    rd_cell(a);
    rd_cell(a ^ 10'h001);
    wr_cell(2'b01, a, rnd(), 2, 1'b1, 1'b0);
    wr_cell(2'b10, a ^ 10'h001, rnd(), 3, 1'b1, 1'b0);
    rd_cell(a);
    rd_cell(a ^ 10'h001);
    tst("writes");
    wr_cell(2'b00, a, 8'h11, 5, 1'b0, 1'b0);
    wr_cell(2'b00, a, 8'h22, 0, 1'b0, 1'b0);
    self_program_busy = 1'b1;
    wr_cell(2'b00, a, 8'h33, 1, 1'b0, 1'b0);
    self_program_busy = 1'b0;
    wr_cell(2'b11, a, 8'h44, 1, 1'b0, 1'b0);
    rd_cell(a);
    tst("refused");
    global_irq_en = 1'b0;
    idle(2);
    `CHK(ready_irq, 1'b0, "ready masked")
    global_irq_en = 1'b1;
    idle(2);
    `CHK(ready_irq, 1'b1, "ready idle")
    wr(EEAC_OFS_STORE_ONE, 8'h3c);
    wr(CT, 8'h18);
    rd(EEAC_OFS_STORE_ONE, 8'h3c);
    sys_rst_n = 1'b0;
    idle(1);
    sys_rst_n = 1'b1;
    rd(EEAC_OFS_STORE_ONE, 8'h00);
    rd(CT, 8'h00);
    idle(3);
    tst("irq and system reset");
    close_out();
  end
endmodule : eeac_control_tb

bind eeac_control eeac_control_props eeac_control_props_i (
  .clk, .nrst, .ce, .sys_rst_n, .io_addr, .io_wdata, .io_we, .io_re, .io_rdata,
  .rc_tick, .self_program_busy, .global_irq_en, .cpu_stall, .ready_irq);

`default_nettype wire
